// *** rtl/burst_pkg.sv ***
package burst_pkg;

  // ----------------------------------------
  // mains and cycle period timing
  // ----------------------------------------
  localparam int HALF_CYCLE_MS = 10;
  localparam int PERIOD_A_MS = 640;
  localparam int PERIOD_B_MS = 5120;
  localparam int PERIOD_C_MS = 40960;
  localparam int PERIOD_D_MS = 327680;
  localparam int REF_LEVELS = 32;
  localparam logic [15:0] STEP_HALVES_A = 16'(PERIOD_A_MS / HALF_CYCLE_MS / REF_LEVELS);
  localparam logic [15:0] STEP_HALVES_B = 16'(PERIOD_B_MS / HALF_CYCLE_MS / REF_LEVELS);
  localparam logic [15:0] STEP_HALVES_C = 16'(PERIOD_C_MS / HALF_CYCLE_MS / REF_LEVELS);
  localparam logic [15:0] STEP_HALVES_D = 16'(PERIOD_D_MS / HALF_CYCLE_MS / REF_LEVELS);

  // ----------------------------------------
  // gate pulse and reset values
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int GATE_PULSE_NS = 100000;
  localparam int GATE_PULSE_CYCLES = (GATE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] REF_LEVEL_RST = 5'h1f;
  localparam logic [15:0] STEP_CNT_RST = 16'h0000;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {
    LINE_ZERO = 2'b00,
    LINE_POS = 2'b01,
    LINE_NEG = 2'b10
  } line_state_t;

  typedef enum logic [0:0] {
    BURST_OFF = 1'b0,
    BURST_ON = 1'b1
  } burst_state_t;

  typedef struct packed {
    logic line_positive_flag;
    logic line_negative_flag;
  } line_sense_t;

  typedef struct packed {
    logic held_high;
    logic held_low;
  } mode_pins_t;

  typedef struct packed {
    logic period_link_hi;
    logic period_link_lo;
  } period_links_t;

endpackage

// *** rtl/burst_fire_triac_controller.sv ***
`timescale 1ns/10ps

// Function
// [R1] bursts odd half cycles, gaps even
// [R2] undervoltage blocks starting a new burst
// [R3] undervoltage ends burst at next legal boundary
// [R4] line sense classed positive, zero, negative
// [R5] positive above common, negative below rail
// [R6] hold logic reset until supply regulated
// [R7] reset pin high during internal reset
// [R8] external reset overrides internal reset
// [R9] mode high forces on, low forces off
// [R10] floating mode follows the demand input
// [R11] links open 0.64s, second tied 5.12s
// [R12] first tied 40.96s, both tied 327.6s
// [R13] retrigger timing from sensed gate voltage
// [R14] polarity governs burst start and end
// [R15] widened gate pulse at each current zero
// [R16] gate drive negative in both halves
// [R17] demand compared to 32-level stepped reference
// [R18] new burst starts opposite previous polarity
// [R19] inputs sampled only at half-cycle boundaries
module burst_fire_triac_controller
  import burst_pkg::*;
#(
  parameter int PULSE_CYCLES = GATE_PULSE_CYCLES
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // supply sense
  input wire logic supply_good,
  input wire logic supply_low,
  // reset pin
  input wire logic ext_reset_in,
  output logic reset_out,
  output logic reset_oe,
  // mains and gate sense
  input wire line_sense_t line_sense_in,
  input wire logic gate_zero_near,
  input wire logic pulse_extend_pin,
  // control inputs
  input wire mode_pins_t mode_in,
  input wire logic demand_above_ref,
  input wire period_links_t period_links,
  // outputs
  output logic gate_drive_out,
  output logic [4:0] ref_level,
  output logic burst_active,
  output line_state_t line_state
);

  // ----------------------------------------
  // reset handling
  // ----------------------------------------
  wire logic supply_reset = rst | ~supply_good;
  wire logic logic_reset = supply_reset | ext_reset_in; // [R6] [R8]

  always_ff @(posedge sys_clk) begin
    reset_out <= supply_reset; // [R7]
    reset_oe <= 1'b1;
  end

  // ----------------------------------------
  // line classification
  // ----------------------------------------
  // both comparators high cannot happen on a sane network; treat as zero
  wire line_state_t line_now =
    (line_sense_in.line_positive_flag & ~line_sense_in.line_negative_flag) ? LINE_POS :
    (line_sense_in.line_negative_flag & ~line_sense_in.line_positive_flag) ? LINE_NEG :
    LINE_ZERO; // [R4] [R5]
  wire logic half_end = (line_now == LINE_ZERO) && (line_state != LINE_ZERO);
  wire logic ended_pos = (line_state == LINE_POS);

  always_ff @(posedge sys_clk) begin
    if (logic_reset) begin
      line_state <= LINE_ZERO;
    end else begin
      line_state <= line_now; // [R4]
    end
  end

  // ----------------------------------------
  // period straps and reference ramp
  // ----------------------------------------
  period_links_t links;
  logic [15:0] step_cnt;

  // straps are fixed at manufacture; caught while reset is held
  always_ff @(posedge sys_clk) begin
    if (logic_reset) begin
      links <= period_links;
    end
  end

  wire logic [15:0] step_len =
    (!links.period_link_hi && !links.period_link_lo) ? STEP_HALVES_A :
    (!links.period_link_hi &&  links.period_link_lo) ? STEP_HALVES_B :
    ( links.period_link_hi && !links.period_link_lo) ? STEP_HALVES_C :
    STEP_HALVES_D; // [R11] [R12]
  wire logic step_wrap = (step_cnt == step_len - 16'h0001);

  always_ff @(posedge sys_clk) begin
    if (logic_reset) begin
      step_cnt <= STEP_CNT_RST;
      ref_level <= REF_LEVEL_RST;
    end else if (half_end) begin
      if (step_wrap) begin
        step_cnt <= STEP_CNT_RST;
        ref_level <= ref_level - 5'h01; // [R17] [R11] [R12]
      end else begin
        step_cnt <= step_cnt + 16'h0001;
      end
    end
  end

  // ----------------------------------------
  // demand decision
  // ----------------------------------------
  wire logic mode_float = ~mode_in.held_high & ~mode_in.held_low;
  wire logic request_now =
    mode_in.held_high ? 1'b1 :
    mode_in.held_low ? 1'b0 : // [R9]
    demand_above_ref; // [R10] [R17]

  // ----------------------------------------
  // burst sequencer
  // ----------------------------------------
  burst_state_t state;
  logic on_odd;
  logic off_odd;
  logic off_any;
  logic first_burst;
  logic start_pos;
  logic arm;

  wire logic off_even = off_any & ~off_odd;
  wire logic pol_ok = first_burst | (ended_pos == start_pos);
  wire logic start_ok = request_now & ~supply_low & off_even & pol_ok; // [R2] [R18] [R19]
  wire logic stop_ok = ~on_odd & (~request_now | supply_low); // [R1] [R3]
  wire logic do_start = (state == BURST_OFF) & half_end & start_ok;
  wire logic do_stop = (state == BURST_ON) & half_end & stop_ok;

  always_ff @(posedge sys_clk) begin
    if (logic_reset) begin
      state <= BURST_OFF;
      on_odd <= 1'b0;
      off_odd <= 1'b0;
      off_any <= 1'b1;
      first_burst <= 1'b1;
      start_pos <= 1'b0;
    end else if (half_end) begin
      unique case (state)
        BURST_OFF: begin
          if (start_ok) begin
            state <= BURST_ON; // [R1] [R14]
            on_odd <= 1'b0;
            first_burst <= 1'b0;
            start_pos <= ~ended_pos; // [R18]
          end else begin
            off_odd <= ~off_odd; // [R1]
            off_any <= 1'b1;
          end
        end
        BURST_ON: begin
          if (stop_ok) begin
            state <= BURST_OFF; // [R1] [R3] [R14]
            // the half after the stop boundary is the first gap half
            off_odd <= 1'b1;
            off_any <= 1'b0;
          end else begin
            on_odd <= ~on_odd;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (logic_reset) begin
      burst_active <= 1'b0;
    end else begin
      burst_active <= (state == BURST_ON);
    end
  end

  // ----------------------------------------
  // gate pulse generation
  // ----------------------------------------
  logic gz_q;
  logic [31:0] pulse_cnt;

  wire logic gz_rise = gate_zero_near & ~gz_q;
  // one retrigger per boundary keeps a half from being fired twice
  wire logic do_retrig = (state == BURST_ON) & arm & gz_rise; // [R13] [R14]
  wire logic fire = do_start | do_retrig;

  always_ff @(posedge sys_clk) begin
    if (logic_reset) begin
      gz_q <= 1'b0;
      arm <= 1'b0;
    end else begin
      gz_q <= gate_zero_near;
      if (do_stop || do_start) begin
        arm <= 1'b0;
      end else if ((state == BURST_ON) && half_end) begin
        arm <= 1'b1; // [R15]
      end else if (do_retrig) begin
        arm <= 1'b0;
      end
    end
  end

  // high output sinks gate current toward the negative rail in either half
  always_ff @(posedge sys_clk) begin
    if (logic_reset) begin
      pulse_cnt <= 32'h0000_0000;
      gate_drive_out <= 1'b0;
    end else if (fire) begin
      pulse_cnt <= 32'(PULSE_CYCLES - 1);
      gate_drive_out <= 1'b1; // [R15] [R16]
    end else if (pulse_cnt != 32'h0000_0000) begin
      pulse_cnt <= pulse_cnt - 32'h0000_0001;
      gate_drive_out <= 1'b1; // [R15]
    end else begin
      gate_drive_out <= gate_drive_out & pulse_extend_pin; // [R15]
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (logic_reset);

  // ----------------------------------------
  // check helpers
  // ----------------------------------------
  // independent half counts; parity checks must not lean on the sequencer's own flags
  logic [3:0] chk_on_halves;
  logic [3:0] chk_off_halves;

  always_ff @(posedge sys_clk) begin
    if (logic_reset) begin
      chk_on_halves <= 4'h0;
      chk_off_halves <= 4'h0;
    end else if (half_end) begin
      if (state == BURST_ON) begin
        chk_on_halves <= chk_on_halves + 4'h1;
        chk_off_halves <= 4'h0;
      end else begin
        chk_off_halves <= chk_off_halves + 4'h1;
        chk_on_halves <= 4'h0;
      end
    end
  end

  a_burst_start_even: assert property ($rose(burst_active) |-> $past(off_even, 2)) // [R1]
    else $error("burst started after odd gap");
  a_burst_stop_odd: assert property ($fell(burst_active) |-> $past(~on_odd, 2)) // [R1]
    else $error("burst ended after even count");
  a_no_start_low: assert property ($rose(burst_active) |-> $past(~supply_low, 2)) // [R2]
    else $error("burst started in undervoltage");
  a_low_ends_burst: assert property (
    (state == BURST_ON) && half_end && supply_low && !on_odd |=> state == BURST_OFF) // [R3]
    else $error("undervoltage did not end burst");
  a_line_class_pos: assert property (
    line_sense_in.line_positive_flag && !line_sense_in.line_negative_flag |=> line_state == LINE_POS) // [R4] [R5]
    else $error("positive line not classified");
  a_reset_pin_high: assert property (@(posedge sys_clk) disable iff (1'b0) !supply_good |=> reset_out) // [R6] [R7]
    else $error("reset pin low during supply reset");
  a_ext_reset_wins: assert property (@(posedge sys_clk) disable iff (rst)
    ext_reset_in |=> !burst_active ##1 !gate_drive_out) // [R8]
    else $error("external reset ignored");
  a_mode_low_off: assert property (
    (state == BURST_ON) && half_end && !on_odd && mode_in.held_low |=> state == BURST_OFF) // [R9]
    else $error("mode low did not stop burst");
  a_float_follows: assert property (
    (state == BURST_OFF) && half_end && off_even && pol_ok && !supply_low && mode_float && demand_above_ref
    |=> state == BURST_ON) // [R10] [R17]
    else $error("demand request not honoured");
  a_alt_start_pol: assert property (
    (state == BURST_OFF) && half_end && start_ok && !first_burst |=> start_pos != $past(start_pos)) // [R18]
    else $error("burst started on same polarity");
  a_pulse_min_width: assert property ($rose(gate_drive_out) |-> gate_drive_out [*8]) // [R15]
    else $error("gate pulse too short");
  a_retrig_armed: assert property (gz_rise && (state == BURST_ON) && arm |=> ##1 gate_drive_out) // [R13]
    else $error("gate zero retrigger missed");
  a_ref_steps_sync: assert property (!half_end |=> $stable(ref_level)) // [R19]
    else $error("reference moved off boundary");

  // ----------------------------------------
  // sequencer, line, gate, reference and reset pin checks
  // ----------------------------------------
  a_on_halves_odd: assert property (do_stop |-> chk_on_halves[0] == 1'b0) // [R1]
    else $error("burst length even");
  a_off_halves_even: assert property (do_start && !first_burst |-> chk_off_halves[0] == 1'b1) // [R1] [R18]
    else $error("gap length odd");
  a_hold_on_odd: assert property ((state == BURST_ON) && half_end && on_odd |=> state == BURST_ON) // [R1] [R3]
    else $error("burst cut on even half");
  a_start_on_edge: assert property ((state == BURST_OFF) && !half_end |=> state == BURST_OFF) // [R19]
    else $error("burst began off a boundary");
  a_low_blocks_start: assert property ((state == BURST_OFF) && supply_low |=> state == BURST_OFF) // [R2]
    else $error("burst began in undervoltage");
  a_mode_high_holds: assert property (
    (state == BURST_ON) && mode_in.held_high && !supply_low |=> state == BURST_ON) // [R9]
    else $error("mode high let burst end");

  a_line_class_neg: assert property (
    line_sense_in.line_negative_flag && !line_sense_in.line_positive_flag |=> line_state == LINE_NEG) // [R4] [R5]
    else $error("negative line not classified");
  a_line_class_zero: assert property (
    line_sense_in.line_negative_flag == line_sense_in.line_positive_flag |=> line_state == LINE_ZERO) // [R4] [R5]
    else $error("near zero not classified");

  a_fire_at_start: assert property (do_start |=> gate_drive_out) // [R14] [R16]
    else $error("no gate pulse at burst start");
  a_arm_idle_off: assert property (state == BURST_OFF |-> !arm) // [R14]
    else $error("retrigger armed outside burst");
  a_retrig_once: assert property (do_retrig && !half_end |=> !arm) // [R14]
    else $error("retrigger left armed");
  // a stuck gate would keep the triac on past the burst end
  a_gate_ends: assert property (
    gate_drive_out && (pulse_cnt == 32'h0000_0000) && !pulse_extend_pin && !fire |=> !gate_drive_out) // [R15]
    else $error("gate pulse overran");

  a_ref_step_down: assert property (half_end && step_wrap |=> ref_level == $past(ref_level) - 5'h01) // [R17]
    else $error("reference step wrong");
  a_step_in_range: assert property (step_cnt < step_len) // [R11] [R12]
    else $error("step count past period");
  a_links_fixed: assert property (1'b1 |=> $stable(links)) // [R11] [R12]
    else $error("period links moved");
  a_reset_pin_on: assert property (reset_oe) // [R7]
    else $error("reset pin not driven");
  a_reset_pin_low: assert property (supply_good && !rst |=> !reset_out) // [R7] [R8]
    else $error("reset pin high in operation");

  c_burst_run: cover property ($rose(burst_active) ##[1:1000] $fell(burst_active));
  c_retrigger: cover property (do_retrig);
  c_low_stop: cover property (do_stop && supply_low);
  c_ref_wrap: cover property (half_end && step_wrap && ref_level == 5'h00);
  c_gap_start: cover property (do_start && !first_burst);

endmodule

// *** tb/mains_triac_model.sv ***
`timescale 1ns/10ps
module mains_triac_model
  import burst_pkg::*;
(
  // clock and test control
  input wire logic sys_clk,
  input wire logic run,
  input wire line_sense_t force_flags,
  // triac side
  input wire logic gate_drive_out,
  output line_sense_t line_sense_in,
  output logic gate_zero_near,
  output logic pulse_extend_pin
);
  // ---
  // 40-cycle mains period, far shorter than real mains
  // ---
  logic [5:0] ph = 6'h00;
  logic [3:0] ext = 4'h0;
  logic on = 1'b0;
  logic g_d = 1'b0;
  always_ff @(posedge sys_clk) begin
    ph <= (ph == 6'h27) ? 6'h00 : ph + 6'h01;
    g_d <= gate_drive_out;
    // triac drops out after a current zero unless the gate is driven again
    on <= gate_drive_out ? 1'b1 : ((ph == 6'h15 || ph == 6'h01) ? 1'b0 : on);
    ext <= (gate_drive_out && !g_d) ? 4'hb : ((ext != 4'h0) ? ext - 4'h1 : 4'h0);
  end
  assign line_sense_in = run ? line_sense_t'({ph < 6'h10, ph > 6'h13 && ph < 6'h24}) : force_flags;
  assign gate_zero_near = run && on && (ph == 6'h12 || ph == 6'h13 || ph == 6'h26 || ph == 6'h27);
  assign pulse_extend_pin = (ext != 4'h0);
endmodule

// *** tb/burst_fire_triac_controller_test.sv ***
`timescale 1ns/10ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("BAD t=%0t got %0h exp %0h", $time, a, e); end end
module burst_fire_triac_controller_test
  import burst_pkg::*;
;
  localparam int PC = 8;
  typedef struct {period_links_t l; line_sense_t f; line_state_t s; int n;} row_t;
  row_t rows[4] = '{'{2'b11, 2'b10, LINE_POS, int'(STEP_HALVES_D)}, '{2'b10, 2'b01, LINE_NEG, int'(STEP_HALVES_C)},
    '{2'b01, 2'b11, LINE_ZERO, int'(STEP_HALVES_B)}, '{2'b00, 2'b00, LINE_ZERO, int'(STEP_HALVES_A)}};
  logic sys_clk = 1'b0, rst = 1'b1, supply_good = 1'b1, supply_low = 1'b0, ext_reset_in = 1'b0;
  logic run = 1'b0, demand_above_ref = 1'b0, reset_out, reset_oe, gate_zero_near, pulse_extend_pin;
  logic gate_drive_out, burst_active, pba = 1'b0, started = 1'b0;
  logic [4:0] ref_level;
  line_sense_t line_sense_in, force_flags = 2'b00;
  mode_pins_t mode_in = 2'b00;
  period_links_t period_links = 2'b00;
  line_state_t line_state, pst = LINE_ZERO;
  int n_mismatch = 0, num_checks = 0, cyc = 0, gw = 0, nb = 0, nh = 0, ng = 0, grises = 0, bursts = 0;
  int nb0, g0, k;
  burst_fire_triac_controller #(.PULSE_CYCLES(PC)) DUT (.sys_clk(sys_clk), .rst(rst),
    .supply_good(supply_good), .supply_low(supply_low), .ext_reset_in(ext_reset_in), .reset_out(reset_out),
    .reset_oe(reset_oe), .line_sense_in(line_sense_in), .gate_zero_near(gate_zero_near),
    .pulse_extend_pin(pulse_extend_pin), .mode_in(mode_in), .demand_above_ref(demand_above_ref),
    .period_links(period_links), .gate_drive_out(gate_drive_out), .ref_level(ref_level),
    .burst_active(burst_active), .line_state(line_state));
  mains_triac_model far_side (.sys_clk(sys_clk), .run(run), .force_flags(force_flags),
    .gate_drive_out(gate_drive_out), .line_sense_in(line_sense_in), .gate_zero_near(gate_zero_near),
    .pulse_extend_pin(pulse_extend_pin));
  initial begin
    forever #10 sys_clk = ~sys_clk;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic halves(input int n);
    repeat (n * 20) @(negedge sys_clk);
  endtask
  // ---
  // half-cycle bookkeeping: boundaries counted against the old burst state
  // ---
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 40000) begin
      n_mismatch++;
      close_out;
    end
    if (gate_drive_out === 1'b1) gw++;
    else if (gw != 0) begin
      `CHK(gw >= PC, 1'b1)
      gw = 0;
    end
    if (gate_drive_out === 1'b1 && gw == 1) grises++;
    if (line_state == LINE_ZERO && pst != LINE_ZERO) begin
      nb++;
      if (burst_active) nh++;
      else ng++;
    end
    pst = line_state;
    if (rst || ext_reset_in || !supply_good) begin
      started = 1'b0;
      pba = 1'b0;
      nh = 0;
      ng = 0;
    end else begin
      if (burst_active && !pba) begin
        if (started) `CHK(ng[0], 1'b0)
        started = 1'b1;
        bursts++;
        ng = 0;
      end
      if (!burst_active && pba) begin
        `CHK(nh[0], 1'b1)
        nh = 0;
      end
      pba = burst_active;
    end
  end
  initial begin
    repeat (8) @(negedge sys_clk);
    `CHK(reset_out, 1'b1)
    `CHK(reset_oe, 1'b1)
    `CHK(gate_drive_out, 1'b0)
    `CHK(ref_level, REF_LEVEL_RST)
    for (int i = 0; i < 4; i++) begin
      period_links = rows[i].l;
      force_flags = rows[i].f;
      run = 1'b0;
      rst = 1'b1;
      repeat (8) @(negedge sys_clk);
      rst = 1'b0;
      repeat (2) @(negedge sys_clk);
      `CHK(line_state, rows[i].s)
      `CHK(reset_out, 1'b0)
      run = 1'b1;
      nb0 = nb;
      for (k = 0; k < 25000 && ref_level === REF_LEVEL_RST; k++) @(negedge sys_clk);
      @(negedge sys_clk);
      `CHK(nb - nb0, rows[i].n)
      $display("test row %0d done", i);
    end
    demand_above_ref = 1'b1;
    halves(12);
    `CHK(bursts > 0, 1'b1)
    mode_in.held_low = 1'b1;
    halves(4);
    g0 = grises;
    halves(8);
    `CHK(grises - g0, 0)
    mode_in = 2'b10;
    supply_low = 1'b1;
    halves(8);
    `CHK(burst_active, 1'b0)
    `CHK(grises - g0, 0)
    supply_low = 1'b0;
    halves(4);
    `CHK(burst_active, 1'b1)
    nb0 = nb;
    g0 = grises;
    halves(10);
    k = (grises - g0) - (nb - nb0);
    `CHK(k * k <= 1, 1'b1)
    supply_low = 1'b1;
    halves(6);
    `CHK(burst_active, 1'b0)
    $display("test modes done");
    ext_reset_in = 1'b1;
    repeat (3) @(negedge sys_clk);
    `CHK(reset_out, 1'b0)
    `CHK(ref_level, REF_LEVEL_RST)
    ext_reset_in = 1'b0;
    supply_good = 1'b0;
    repeat (3) @(negedge sys_clk);
    `CHK(reset_out, 1'b1)
    `CHK(gate_drive_out, 1'b0)
    supply_good = 1'b1;
    repeat (3) @(negedge sys_clk);
    `CHK(reset_out, 1'b0)
    $display("test resets done");
    close_out;
  end
endmodule
